// File: mrm_top.sv
// Register map and two-wire slave of a battery monitor.
// Assumes SCL/SDA arrive asynchronously and converters share sys_clk.
//
// Function
// - Upper byte read snapshots both bytes
// - Status register read/write, status bits read-only
// - Power-up flag set at reset, write-zero clears
// - Sleep allowed only when sleep bit set
// - Blank enable bit steers discharge blanking
// - Divider driven before aux conversions unless disabled
// - Second aux valid set after enabled conversion
// - First aux valid set after enabled conversion
// - Measurement registers mapped, read-only, reset zero
// - Charge count at 10/11 read/write
// - Slave only, open-drain SDA
// - SDA stable while SCL high
// - Detect start and stop conditions
// - Repeated start begins new transaction
// - Both lines high when bus idle
// - Acknowledge pulls SDA low ninth clock
// - No-acknowledge leaves SDA released
// - Bytes msb first, upper byte even address
// - Acknowledge only own slave address
// - Pointer advances after each data byte
// - Illegal or partial writes leave memory
// - Reads past end return all ones
`timescale 1ns/1ps
`include "mrm_params.svh"

module mrm_top #(
  parameter int PRECHARGE_CYCLES = `MRM_PRECHARGE_CYCLES,
  parameter int SLEEP_CYCLES = `MRM_SLEEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire mrm_pkg::mrm_meas_type meas,
  input wire logic meas_update,
  input wire logic charge_update,
  input wire logic aux_cycle_req,
  input wire logic aux0_done,
  input wire logic aux1_done,
  output mrm_pkg::mrm_cfg_type cfg,
  output logic aux_first_valid,
  output logic aux_second_valid,
  output logic [15:0] charge_count,
  output logic charge_write,
  output logic divider_supply_output,
  output logic aux_convert_go,
  output logic sleep_request
);
  import mrm_pkg::*;

  if (PRECHARGE_CYCLES < 1 || PRECHARGE_CYCLES > 65535) begin : g_chk_pre
    $error("PRECHARGE_CYCLES out of range");
  end
  if (SLEEP_CYCLES < 1 || SLEEP_CYCLES > 65535) begin : g_chk_slp
    $error("SLEEP_CYCLES out of range");
  end

  localparam logic [15:0] PRE_LAST = 16'(PRECHARGE_CYCLES - 1);
  localparam logic [15:0] SLP_LAST = 16'(SLEEP_CYCLES);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n_s;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_r[1];

  mrm_regs_type r_r, r_nxt;
  logic scl_rise, scl_fall, start_ev, stop_ev, load;
  logic [7:0] rd_byte, wr_pos;

  function automatic logic [7:0] reg_read(mrm_regs_type s, logic [7:0] a);
    case (a)
      `MRM_ADDR_STATUS: reg_read = s.status;
      `MRM_ADDR_AUX0_HI: reg_read = s.meas.aux0[15:8];
      `MRM_ADDR_AUX0_LO: reg_read = s.meas.aux0[7:0];
      `MRM_ADDR_AUX1_HI: reg_read = s.meas.aux1[15:8];
      `MRM_ADDR_AUX1_LO: reg_read = s.meas.aux1[7:0];
      `MRM_ADDR_VOLT_HI: reg_read = s.meas.voltage[15:8];
      `MRM_ADDR_VOLT_LO: reg_read = s.meas.voltage[7:0];
      `MRM_ADDR_CURR_HI: reg_read = s.meas.current[15:8];
      `MRM_ADDR_CURR_LO: reg_read = s.meas.current[7:0];
      `MRM_ADDR_CHG_HI: reg_read = s.charge[15:8];
      `MRM_ADDR_CHG_LO: reg_read = s.charge[7:0];
      `MRM_ADDR_OFFSET: reg_read = s.offset_trim;
      `MRM_ADDR_SKEW: reg_read = s.skew;
      // Reserved space reads as zero
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    r_nxt.charge_wr = 1'b0;
    r_nxt.go = 1'b0;
    load = 1'b0;
    wr_pos = r_r.ptr;
    r_nxt.scl_m = scl_i;
    r_nxt.scl_s = r_r.scl_m;
    r_nxt.scl_p = r_r.scl_s;
    r_nxt.sda_m = sda_i;
    r_nxt.sda_s = r_r.sda_m;
    r_nxt.sda_p = r_r.sda_s;
    scl_rise = r_r.scl_s & ~r_r.scl_p;
    scl_fall = ~r_r.scl_s & r_r.scl_p;
    // edges of SDA while SCL high
    start_ev = r_r.scl_s & r_r.scl_p & r_r.sda_p & ~r_r.sda_s;
    stop_ev = r_r.scl_s & r_r.scl_p & ~r_r.sda_p & r_r.sda_s;

    if (meas_update) begin
      r_nxt.meas.aux0 = meas.aux0;
      r_nxt.meas.aux1 = meas.aux1;
      r_nxt.meas.voltage = meas.voltage;
      r_nxt.meas.current = meas.current;
    end
    if (charge_update) begin
      r_nxt.charge = meas.charge;
    end

    if (start_ev) begin
      r_nxt.st = MRM_ADDR;
      r_nxt.cnt = 4'h0;
      r_nxt.sda_oe = 1'b0;
      r_nxt.snap_v = 1'b0;
    end else if (stop_ev) begin
      // stop returns to idle, line released
      r_nxt.st = MRM_IDLE;
      r_nxt.sda_oe = 1'b0;
      r_nxt.snap_v = 1'b0;
    end else begin
      case (r_r.st)
        MRM_IDLE: begin
          r_nxt.sda_oe = 1'b0;
        end
        MRM_ADDR: begin
          if (scl_rise) begin
            r_nxt.sh = {r_r.sh[6:0], r_r.sda_s};
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (scl_fall && r_r.cnt == `MRM_BITS_PER_BYTE) begin
            if (r_r.sh[7:1] == `MRM_SLAVE_ID) begin
              r_nxt.st = MRM_ACK_ADDR;
              r_nxt.rw = r_r.sh[0];
              r_nxt.sda_oe = 1'b1;
            end else begin
              r_nxt.st = MRM_IDLE;
            end
          end
        end
        MRM_ACK_ADDR: begin
          if (scl_fall) begin
            r_nxt.cnt = 4'h0;
            if (r_r.rw) begin
              r_nxt.st = MRM_READ;
              load = 1'b1;
            end else begin
              r_nxt.st = MRM_WRITE;
              r_nxt.ptr_phase = 1'b1;
              r_nxt.sda_oe = 1'b0;
            end
          end
        end
        MRM_WRITE: begin
          if (scl_rise) begin
            r_nxt.sh = {r_r.sh[6:0], r_r.sda_s};
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (scl_fall && r_r.cnt == `MRM_BITS_PER_BYTE) begin
            // pull low through the ninth clock
            r_nxt.st = MRM_ACK_W;
            r_nxt.sda_oe = 1'b1;
            if (r_r.ptr_phase) begin
              r_nxt.ptr_phase = 1'b0;
              r_nxt.ptr = r_r.sh;
              r_nxt.ovf = 1'b0;
            end else begin
              r_nxt.ptr = r_r.ptr + 8'h01;
              r_nxt.ovf = r_r.ovf | (r_r.ptr == `MRM_PAST_END);
              if (!r_r.ovf && r_r.ptr <= `MRM_WRITE_LIMIT) begin
                case (wr_pos)
                  `MRM_ADDR_STATUS: begin
                    r_nxt.status = (r_r.status & ~`MRM_STATUS_RW_MASK)
                      | (r_r.sh & `MRM_STATUS_RW_MASK);
                    r_nxt.status[`MRM_BIT_POWER_UP] =
                      r_r.status[`MRM_BIT_POWER_UP]
                      & r_r.sh[`MRM_BIT_POWER_UP];
                  end
                  `MRM_ADDR_CHG_HI: begin
                    r_nxt.charge[15:8] = r_r.sh;
                    r_nxt.charge_wr = 1'b1;
                  end
                  `MRM_ADDR_CHG_LO: begin
                    r_nxt.charge[7:0] = r_r.sh;
                    r_nxt.charge_wr = 1'b1;
                  end
                  default: begin
                  end
                endcase
              end
              // bias bytes sit above the write limit
              if (!r_r.ovf && r_r.ptr == `MRM_ADDR_OFFSET) begin
                r_nxt.offset_trim = r_r.sh;
              end
              if (!r_r.ovf && r_r.ptr == `MRM_ADDR_SKEW) begin
                r_nxt.skew = r_r.sh;
              end
            end
          end
        end
        MRM_ACK_W: begin
          if (scl_fall) begin
            r_nxt.st = MRM_WRITE;
            r_nxt.cnt = 4'h0;
            r_nxt.sda_oe = 1'b0;
          end
        end
        MRM_READ: begin
          // shift out msb first on SCL falling
          if (scl_fall) begin
            if (r_r.cnt == `MRM_LAST_TX_BIT) begin
              r_nxt.st = MRM_ACK_R;
              r_nxt.sda_oe = 1'b0;
              r_nxt.ptr = r_r.ptr + 8'h01;
              r_nxt.ovf = r_r.ovf | (r_r.ptr == `MRM_PAST_END);
            end else begin
              r_nxt.cnt = r_r.cnt + 4'h1;
              r_nxt.tx = {r_r.tx[6:0], 1'b1};
              r_nxt.sda_oe = ~r_r.tx[6];
            end
          end
        end
        MRM_ACK_R: begin
          if (scl_rise) begin
            r_nxt.nack = r_r.sda_s;
          end else if (scl_fall) begin
            if (r_r.nack) begin
              r_nxt.st = MRM_IDLE;
            end else begin
              r_nxt.st = MRM_READ;
              r_nxt.cnt = 4'h0;
              load = 1'b1;
            end
          end
        end
        default: begin
          r_nxt.st = MRM_IDLE;
          r_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // past the top of memory read all ones
    if (r_r.ovf) begin
      rd_byte = `MRM_PAST_END;
    end else if (r_r.snap_v && r_r.ptr == r_r.snap_addr + 8'h01) begin
      rd_byte = r_r.snap_lo;
    end else begin
      rd_byte = reg_read(r_r, r_r.ptr);
    end
    if (load) begin
      r_nxt.tx = rd_byte;
      // open-drain, enable only to pull low
      r_nxt.sda_oe = ~rd_byte[7];
      // upper byte read freezes the lower
      if (!r_r.ovf && !r_r.ptr[0] && r_r.ptr >= `MRM_ADDR_AUX0_HI
          && r_r.ptr <= `MRM_ADDR_CHG_HI) begin
        r_nxt.snap_v = 1'b1;
        r_nxt.snap_addr = r_r.ptr;
        r_nxt.snap_lo = reg_read(r_r, r_r.ptr + 8'h01);
      end
    end

    // ----------------------------------------------------------------
    // Divider supply sequencing
    // ----------------------------------------------------------------
    case (r_r.div_phase)
      2'h0: begin
        if (aux_cycle_req) begin
          r_nxt.div_phase = 2'h1;
          r_nxt.pre_cnt = 16'h0000;
          r_nxt.status[`MRM_BIT_AUX0] = 1'b0;
          r_nxt.status[`MRM_BIT_AUX1] = 1'b0;
        end
      end
      2'h1: begin
        r_nxt.pre_cnt = r_r.pre_cnt + 16'h0001;
        if (r_r.pre_cnt == PRE_LAST) begin
          r_nxt.div_phase = 2'h2;
          r_nxt.go = 1'b1;
        end
      end
      default: begin
        if (aux1_done) begin
          r_nxt.div_phase = 2'h0;
        end
      end
    endcase
    r_nxt.div_out = ~r_nxt.status[`MRM_BIT_DIV_DIS]
      & (r_nxt.div_phase != 2'h0);
    if (aux0_done && r_r.div_out) begin
      r_nxt.status[`MRM_BIT_AUX0] = 1'b1;
    end
    if (aux1_done && r_r.div_out) begin
      r_nxt.status[`MRM_BIT_AUX1] = 1'b1;
    end

    // sleep after both lines low long enough
    if (r_r.status[`MRM_BIT_SLEEP] && !r_r.scl_s && !r_r.sda_s) begin
      if (r_r.slp_cnt != SLP_LAST) begin
        r_nxt.slp_cnt = r_r.slp_cnt + 16'h0001;
      end
    end else begin
      r_nxt.slp_cnt = 16'h0000;
    end
    r_nxt.sleep = r_r.status[`MRM_BIT_SLEEP] && r_r.slp_cnt == SLP_LAST;
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      r_r <= '0;
      r_r.scl_m <= 1'b1;
      r_r.scl_s <= 1'b1;
      r_r.scl_p <= 1'b1;
      r_r.sda_m <= 1'b1;
      r_r.sda_s <= 1'b1;
      r_r.sda_p <= 1'b1;
      r_r.st <= MRM_IDLE;
      r_r.status <= `MRM_STATUS_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_o = 1'b0;
  assign sda_oe = r_r.sda_oe;
  assign cfg.power_up_flag = r_r.status[`MRM_BIT_POWER_UP];
  assign cfg.sleep_allow = r_r.status[`MRM_BIT_SLEEP];
  assign cfg.discharge_blank_enable = r_r.status[`MRM_BIT_BLANK];
  assign cfg.divider_output_disable = r_r.status[`MRM_BIT_DIV_DIS];
  assign cfg.current_offset_trim = r_r.offset_trim;
  assign cfg.accumulation_skew = r_r.skew;
  assign aux_first_valid = r_r.status[`MRM_BIT_AUX0];
  assign aux_second_valid = r_r.status[`MRM_BIT_AUX1];
  assign charge_count = r_r.charge;
  assign charge_write = r_r.charge_wr;
  assign divider_supply_output = r_r.div_out;
  assign aux_convert_go = r_r.go;
  assign sleep_request = r_r.sleep;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n_s);

  logic ev_any;
  assign ev_any = start_ev | stop_ev;

  a_start_frames: assert property (start_ev |=> r_r.st == MRM_ADDR)
    else $error("start did not open address phase");
  a_stop_idles: assert property (stop_ev
    |=> r_r.st == MRM_IDLE && !sda_oe)
    else $error("stop did not idle and release");
  a_addr_match: assert property (r_r.st == MRM_ADDR && scl_fall
    && r_r.cnt == `MRM_BITS_PER_BYTE && r_r.sh[7:1] == `MRM_SLAVE_ID
    && !ev_any |=> sda_oe && r_r.st == MRM_ACK_ADDR)
    else $error("own address not acknowledged");
  a_addr_other: assert property (r_r.st == MRM_ADDR && scl_fall
    && r_r.cnt == `MRM_BITS_PER_BYTE && r_r.sh[7:1] != `MRM_SLAVE_ID
    && !ev_any |=> !sda_oe ##1 !sda_oe)
    else $error("foreign address acknowledged");
  a_sda_stable: assert property (r_r.scl_s && $past(r_r.scl_s)
    && !$past(ev_any) |-> $stable(sda_oe))
    else $error("SDA moved while SCL high");
  a_por_sticky: assert property (!cfg.power_up_flag
    |=> !cfg.power_up_flag)
    else $error("power-up flag set again");
  a_resv_zero: assert property (r_r.status[`MRM_BIT_RESV_HI] == 1'b0
    && r_r.status[`MRM_BIT_RESV_LO] == 1'b0)
    else $error("reserved status bit set");
  a_snap_hold: assert property (r_r.snap_v && !ev_any && !load
    |=> $stable(r_r.snap_lo) && $stable(r_r.snap_addr))
    else $error("snapshot changed during read");
  a_snap_free: assert property (ev_any |=> !r_r.snap_v)
    else $error("snapshot kept past command end");
  a_past_end: assert property (load && r_r.ovf
    |=> r_r.tx == `MRM_PAST_END)
    else $error("read past end not all ones");
  a_div_off: assert property (cfg.divider_output_disable
    |=> !divider_supply_output)
    else $error("divider driven while disabled");
  a_sleep_gate: assert property (!cfg.sleep_allow |=> !sleep_request)
    else $error("sleep requested while blocked");

  c_read_ack: cover property (r_r.st == MRM_ACK_ADDR && r_r.rw);
  c_write_ack: cover property (r_r.st == MRM_ACK_W && !r_r.ptr_phase);
  c_restart: cover property (start_ev && r_r.st != MRM_IDLE);
  c_sleep: cover property (sleep_request);

endmodule : mrm_top

// File: mrm_params.svh
// Constants for the monitor register map and its two-wire slave.
// Assumes inclusion by mrm_pkg.sv, mrm_top.sv and the self-checking bench.
`ifndef MRM_PARAMS_SVH
`define MRM_PARAMS_SVH

// ----------------------------------------------------------------
// Bus identity and framing
// ----------------------------------------------------------------
`define MRM_SLAVE_ID 7'h36
`define MRM_BITS_PER_BYTE 4'h8
`define MRM_LAST_TX_BIT 4'h7
`define MRM_WRITE_LIMIT 8'h4F
`define MRM_PAST_END 8'hFF

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MRM_ADDR_STATUS 8'h01
`define MRM_ADDR_AUX0_HI 8'h08
`define MRM_ADDR_AUX0_LO 8'h09
`define MRM_ADDR_AUX1_HI 8'h0A
`define MRM_ADDR_AUX1_LO 8'h0B
`define MRM_ADDR_VOLT_HI 8'h0C
`define MRM_ADDR_VOLT_LO 8'h0D
`define MRM_ADDR_CURR_HI 8'h0E
`define MRM_ADDR_CURR_LO 8'h0F
`define MRM_ADDR_CHG_HI 8'h10
`define MRM_ADDR_CHG_LO 8'h11
`define MRM_ADDR_OFFSET 8'h61
`define MRM_ADDR_SKEW 8'h62

// ----------------------------------------------------------------
// Status/config fields and reset value
// ----------------------------------------------------------------
`define MRM_BIT_POWER_UP 6
`define MRM_BIT_SLEEP 5
`define MRM_BIT_BLANK 4
`define MRM_BIT_DIV_DIS 3
`define MRM_BIT_AUX1 1
`define MRM_BIT_AUX0 0
`define MRM_BIT_RESV_HI 7
`define MRM_BIT_RESV_LO 2
`define MRM_STATUS_RESET 8'h70
`define MRM_STATUS_RW_MASK 8'h38

// ----------------------------------------------------------------
// Timing defaults in sys_clk cycles
// ----------------------------------------------------------------
`define MRM_PRECHARGE_CYCLES 256
`define MRM_SLEEP_CYCLES 50000

`endif

// File: mrm_pkg.sv
// Types shared by the monitor register map block.
// Assumes mrm_params.svh is on the include path.
`include "mrm_params.svh"

package mrm_pkg;

  // Gray coded along address, ack, data, ack
  typedef enum logic [2:0] {
    MRM_IDLE = 3'h0,
    MRM_ADDR = 3'h1,
    MRM_ACK_ADDR = 3'h3,
    MRM_WRITE = 3'h2,
    MRM_ACK_W = 3'h6,
    MRM_READ = 3'h7,
    MRM_ACK_R = 3'h5
  } mrm_state_enum_type;

  typedef struct packed {
    logic [15:0] aux0;
    logic [15:0] aux1;
    logic [15:0] voltage;
    logic [15:0] current;
    logic [15:0] charge;
  } mrm_meas_type;

  typedef struct packed {
    logic power_up_flag;
    logic sleep_allow;
    logic discharge_blank_enable;
    logic divider_output_disable;
    logic [7:0] current_offset_trim;
    logic [7:0] accumulation_skew;
  } mrm_cfg_type;

  typedef struct packed {
    logic scl_m, scl_s, scl_p;
    logic sda_m, sda_s, sda_p;
    mrm_state_enum_type st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic rw, ptr_phase, nack, ovf;
    logic [7:0] ptr;
    logic snap_v;
    logic [7:0] snap_addr;
    logic [7:0] snap_lo;
    logic sda_oe;
    logic [7:0] status;
    logic [7:0] offset_trim;
    logic [7:0] skew;
    logic [15:0] charge;
    logic charge_wr;
    mrm_meas_type meas;
    logic [1:0] div_phase;
    logic div_out;
    logic go;
    logic [15:0] pre_cnt;
    logic [15:0] slp_cnt;
    logic sleep;
  } mrm_regs_type;

endpackage : mrm_pkg

// File: mrm_host_model.sv
// Host stand-in: two-wire bus master, 8 sys_clk per bit (32 ns).
// Assumes SDA is pulled up by the bench and clk is sys_clk.
`timescale 1ns/1ps

module mrm_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  // both lines released when idle
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  // start, also as repeated start
  // Extra wait lets a slave ack release before SCL rises
  task automatic start;
    sda_low <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(3);
    sda_low <= 1'b1;
    w(3);
    scl <= 1'b0;
    w(2);
  endtask : start
  task automatic stop;
    sda_low <= 1'b1;
    w(3);
    scl <= 1'b1;
    w(3);
    sda_low <= 1'b0;
    w(3);
  endtask : stop
  // data moves only while SCL low
  task automatic bitx(input logic b, output logic r);
    sda_low <= ~b;
    w(3);
    scl <= 1'b1;
    w(3);
    r = sda;
    scl <= 1'b0;
    w(2);
  endtask : bitx
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  // ack all but the last byte
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(~mack, r);
  endtask : rd_byte
endmodule : mrm_host_model

// File: mrm_top_tb_top.sv
// Self-checking bench for the monitor register map and slave.
// Assumes mrm_host_model drives the bus; SDA pull-up made here.
`timescale 1ns/1ps
`include "mrm_params.svh"

module mrm_top_tb_top;
  import mrm_pkg::*;
  localparam int PRE = 4;
  localparam int SLP = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, host_low, sda_o, sda_oe, av0, av1, div_out, go, slp_req;
  wire sda_w;
  mrm_meas_type meas = '0;
  // Strobes: measure, charge, aux cycle, aux0 done, aux1 done
  localparam int S_MEAS = 0, S_CHG = 1, S_AUX = 2, S_DONE0 = 3, S_DONE1 = 4;
  logic [4:0] strb = 5'h00;
  logic chg_wr;
  int n_chg_wr = 0;
  mrm_cfg_type cfg;
  logic [15:0] chg;
  logic [7:0] mdl [0:255];
  logic [63:0] pend;
  int mismatches = 0;
  int n_compared = 0;

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (chg_wr === 1'b1)
      n_chg_wr++;
  assign sda_w = ~(host_low | (sda_oe & ~sda_o));

  mrm_host_model host_u (.clk(sys_clk), .sda(sda_w), .scl(scl),
    .sda_low(host_low));
  mrm_top #(.PRECHARGE_CYCLES(PRE), .SLEEP_CYCLES(SLP)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .meas(meas),
    .meas_update(strb[S_MEAS]), .charge_update(strb[S_CHG]),
    .aux_cycle_req(strb[S_AUX]), .aux0_done(strb[S_DONE0]),
    .aux1_done(strb[S_DONE1]), .cfg(cfg), .aux_first_valid(av0),
    .aux_second_valid(av1), .charge_count(chg), .charge_write(chg_wr),
    .divider_supply_output(div_out), .aux_convert_go(go),
    .sleep_request(slp_req));

  // ----------------------------------------
  // Reference model and checks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [23:0] e,
    input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic void mdl_wr(input int a, input logic [7:0] d);
    if (a == 1)
      mdl[1] = {1'b0, mdl[1][6] & d[6], d[5:3], 1'b0, mdl[1][1:0]};
    else if (a == 16 || a == 17 || a == 97 || a == 98)
      mdl[a] = d;
  endfunction : mdl_wr
  function automatic bit known(input int a);
    return a > 255 || a == 1 || (a >= 8 && a <= 17) || a == 97 || a == 98;
  endfunction : known
  function automatic void apply;
    for (int j = 0; j < 8; j++)
      mdl[8 + j] = pend[63 - 8 * j -: 8];
  endfunction : apply
  task automatic pulse(input int b);
    @(posedge sys_clk);
    strb[b] <= 1'b1;
    @(posedge sys_clk);
    strb[b] <= 1'b0;
  endtask : pulse
  task automatic set_meas(input bit defer);
    pend = {$urandom, $urandom};
    @(posedge sys_clk);
    meas <= {pend, meas.charge};
    pulse(S_MEAS);
    if (!defer)
      apply();
  endtask : set_meas
  task automatic wr(input logic [7:0] a, input logic [7:0] d [$]);
    logic k;
    host_u.start();
    host_u.wr_byte({`MRM_SLAVE_ID, 1'b0}, k);
    chk("write ack", 1'b1, k);
    host_u.wr_byte(a, k);
    foreach (d[i]) begin
      host_u.wr_byte(d[i], k);
      mdl_wr(a + i, d[i]);
    end
    host_u.stop();
    chk("cfg", {mdl[1][6:3], mdl[97], mdl[98]}, cfg);
    chk("charge", {mdl[16], mdl[17]}, chg);
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n, input bit upd);
    logic k;
    logic [7:0] v;
    host_u.start();
    host_u.wr_byte({`MRM_SLAVE_ID, 1'b0}, k);
    host_u.wr_byte(a, k);
    host_u.start();
    host_u.wr_byte({`MRM_SLAVE_ID, 1'b1}, k);
    chk("read ack", 1'b1, k);
    for (int i = 0; i < n; i++) begin
      if (upd && i == 0)
        fork
          set_meas(1'b1);
        join_none
      host_u.rd_byte(i < n - 1, v);
      if (known(a + i))
        chk($sformatf("reg %h", a + i),
          (a + i > 255) ? `MRM_PAST_END : mdl[a + i], v);
    end
    host_u.stop();
    if (upd)
      apply();
  endtask : rd
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic k;
    logic [15:0] c;
    int n;
    for (int i = 0; i < 256; i++)
      mdl[i] = 8'h00;
    mdl[1] = 8'h70;
    void'($urandom(32'hD044));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("sda value", 1'b0, sda_o);
    chk("cfg reset", {mdl[1][6:3], 16'h0000}, cfg);
    rd(8'h01, 1, 0);
    rd(8'h08, 10, 0);
    rd(8'h61, 2, 0);
    $display("Test reset done");
    wr(8'h61, '{8'($urandom), 8'($urandom)});
    rd(8'h61, 2, 0);
    wr(8'h01, '{8'h00});
    rd(8'h01, 1, 0);
    wr(8'h01, '{8'hFF});
    rd(8'h01, 1, 0);
    $display("Test registers done");
    set_meas(1'b0);
    rd(8'h08, 8, 0);
    rd(8'h0C, 2, 1);
    rd(8'h0C, 4, 0);
    c = 16'($urandom);
    meas.charge <= c;
    pulse(S_CHG);
    {mdl[16], mdl[17]} = c;
    rd(8'h10, 2, 0);
    n = n_chg_wr;
    wr(8'h10, '{8'($urandom), 8'($urandom)});
    chk("charge writes", 24'h000002, 24'(n_chg_wr - n));
    rd(8'h10, 2, 0);
    $display("Test measurements done");
    n = n_chg_wr;
    wr(8'h0E, '{8'h12, 8'h34});
    wr(8'h4F, '{8'h55, 8'h66});
    host_u.start();
    host_u.wr_byte({`MRM_SLAVE_ID, 1'b0}, k);
    host_u.wr_byte(8'h61, k);
    for (int i = 0; i < 4; i++)
      host_u.bitx(1'b0, k);
    host_u.stop();
    chk("no charge write", 24'h000000, 24'(n_chg_wr - n));
    rd(8'h0E, 2, 0);
    rd(8'h61, 2, 0);
    rd(8'hFE, 4, 0);
    host_u.start();
    host_u.wr_byte({`MRM_SLAVE_ID ^ 7'h01, 1'b0}, k);
    chk("foreign ack", 1'b0, k);
    host_u.stop();
    wr(8'h62, '{8'($urandom)});
    $display("Test bus rules done");
    for (int dis = 1; dis >= 0; dis--) begin
      wr(8'h01, '{{4'h3, dis[0], 3'h0}});
      pulse(S_AUX);
      @(posedge sys_clk);
      chk("divider on", dis == 0, div_out);
      k = 1'b0;
      repeat (PRE + 8) begin
        @(posedge sys_clk);
        k |= go;
      end
      if (dis == 0)
        chk("convert go", 1'b1, k);
      pulse(S_DONE0);
      pulse(S_DONE1);
      repeat (2) @(posedge sys_clk);
      chk("divider off", 1'b0, div_out);
      mdl[1][1:0] = {2{dis == 0}};
      chk("valid", mdl[1][1:0], {av1, av0});
      rd(8'h01, 1, 0);
      // aux results read only once both valid
      if (mdl[1][1:0] == 2'h3)
        rd(8'h08, 4, 0);
    end
    $display("Test divider done");
    for (int s = 0; s < 2; s++) begin
      wr(8'h01, '{{2'h0, s[0], 5'h10}});
      host_u.start();
      repeat (SLP + 12) @(posedge sys_clk);
      chk("sleep", s[0], slp_req);
      host_u.stop();
    end
    $display("Test sleep done");
    close_out();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    close_out();
  end
endmodule : mrm_top_tb_top
